// >>> srm_top.sv
// Reference, mute and modulation configuration slice with AHB-Lite registers.
// Assumes a single AHB master and one synchronous system clock.
// Function
// R1: Software writes 11Fh to lock-detect upper bits
// R2: Software writes 1h to bits 2-1
// R3: Pin select chooses readback data or lock
// R4: Lock detect runs only when enabled
// R5: Software writes zero to reserved bits
// R6: Wait settle count reference cycles
// R7: Software never programs settle count zero
// R8: Settle wait in every switch sequence
// R9: Auto-mute holds outputs muted until lock
// R10: Lock loss after unmute never re-mutes
// R11: Buffer type bits: open drain or push-pull
// R12: Termination enable works in any input kind
// R13: Kind bit selects single-ended or differential
// R14: Crystal resistor codes 0-3; 4-7 reserved
// R15: Crystal buffer overrides input kind
// R16: Frame-sync polarity in serial mode
// R17: Serial clock sampling edge in serial mode
// R18: Level field selects modulation level count
// R19: Level zero disables pin and register modes
// R20: Deviation select picks stored word index
// R21: Mode bits choose pin, register, serial, fast
// R22: Registers 16-bit, reset, read back writes
`timescale 1ns/1ps
`default_nettype none
module srm_top
    import srm_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic resetn_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [9:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic hready_in,
    input wire logic [31:0] hwdata_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Loop and sequencing inputs
    input wire logic readback_data_in,
    input wire logic lock_in,
    input wire logic ref_tick_in,
    input wire logic switch_start_in,
    input wire logic vco_change_in,
    input wire logic profile_switch_in,
    // Modulation inputs
    input wire logic profile_modulation_enable_in,
    input wire logic frame_sync_in,
    input wire logic serial_clk_in,
    // Pin and loop outputs
    output logic multipurpose_output_pin_out,
    output logic lock_detect_out,
    output logic settle_busy_out,
    output logic settle_done_out,
    output logic muted_out,
    // Output buffer and reference input controls
    output logic transmit_buffer_type_out,
    output logic receive_buffer_type_out,
    output logic ref_input_termination_out,
    output logic ref_input_differential_out,
    output logic crystal_buffer_enable_out,
    output logic [2:0] crystal_series_resistor_out,
    // Modulation controls
    output logic [1:0] modulation_source_mode_out,
    output logic modulation_enable_out,
    output logic [1:0] shift_level_count_out,
    output logic [2:0] deviation_index_out,
    output logic frame_sync_active_out,
    output logic serial_clock_strobe_out
);
    logic [1:0] rst_sync; // Reset release synchroniser
    logic rst_n; // Synchronised reset used everywhere below
    logic [15:0] ref_mod_cfg; // Reference and modulation register
    logic [15:0] mute_settle_cfg; // Mute and settle register
    logic [15:0] lock_det_cfg; // Lock detect register
    logic wr_pending; // Write data phase outstanding
    logic [7:0] wr_index; // Register index of that write
    logic addr_valid; // Address phase accepted this cycle
    logic serial_clk_prev; // Previous serial clock level
    logic [1:0] mode; // Decoded modulation mode
    logic level_mode; // Pin or register mode, where levels apply
    logic sample_edge; // Selected serial clock edge seen

    // Word index from a byte address
    function automatic logic [7:0] reg_index(input logic [9:0] addr);
        reg_index = addr[9:2];
    endfunction

    // Register read value, zero for unmapped indices
    function automatic logic [15:0] reg_value(input logic [7:0] idx,
            input logic [15:0] rm, input logic [15:0] ms, input logic [15:0] ld);
        unique case (idx)
            IDX_REF_MOD: reg_value = rm;
            IDX_MUTE_SETTLE: reg_value = ms;
            IDX_LOCK_DET: reg_value = ld;
            default: reg_value = 16'h0000;
        endcase
    endfunction

    // Release reset through two flip-flops; assertion stays asynchronous
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Zero-wait slave: every transfer completes at once with OKAY
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign addr_valid = hsel_in && hready_in && (htrans_in == HTRANS_NONSEQ);

    // Remember a write address phase for its data phase
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            wr_pending <= 1'b0;
            wr_index <= 8'h00;
        end else if (hready_in) begin
            wr_pending <= addr_valid && hwrite_in;
            wr_index <= reg_index(haddr_in);
        end
    end

    // Register writes; reserved bits are stored as written and never forced
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            ref_mod_cfg <= RST_REF_MOD; // R22
            mute_settle_cfg <= RST_MUTE_SETTLE; // R22
            lock_det_cfg <= RST_LOCK_DET; // R22
        end else if (wr_pending) begin
            unique case (wr_index)
                IDX_REF_MOD: ref_mod_cfg <= hwdata_in[15:0]; // R22
                IDX_MUTE_SETTLE: mute_settle_cfg <= hwdata_in[15:0]; // R22
                IDX_LOCK_DET: lock_det_cfg <= hwdata_in[15:0]; // R22
                default: ; // Unmapped writes are dropped
            endcase
        end
    end

    // Read data is captured at the address phase and held for the data phase.
    // The master idles between singles, so no write can slip in between.
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            hrdata_out <= 32'h0000_0000;
        end else if (addr_valid && !hwrite_in) begin
            hrdata_out <= {16'h0000, reg_value(reg_index(haddr_in),
                ref_mod_cfg, mute_settle_cfg, lock_det_cfg)}; // R22
        end
    end

    // Lock indication runs only while enabled; pin shows it or readback data
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            lock_detect_out <= 1'b0;
            multipurpose_output_pin_out <= 1'b0;
        end else begin
            lock_detect_out <= lock_det_cfg[LOCK_DETECT_ENABLE_BIT] && lock_in; // R4
            if (lock_det_cfg[LD_PIN_SEL_BIT]) begin
                multipurpose_output_pin_out <= lock_det_cfg[LOCK_DETECT_ENABLE_BIT] && lock_in; // R3
            end else begin
                multipurpose_output_pin_out <= readback_data_in; // R3
            end
        end
    end

    // Settle wait runs on every switch start seen while idle, whether or not the multiplier is used
    srm_settle_timer #(
        .CW(MS_SETTLE_W)
    ) srm_settle_timer_inst (
        .clk_in(mclk_in),
        .rst_n_in(rst_n),
        .start_in(switch_start_in),
        .ref_tick_in(ref_tick_in),
        .count_in(mute_settle_cfg[MS_SETTLE_LSB +: MS_SETTLE_W]),
        .busy_out(settle_busy_out),
        .done_out(settle_done_out)
    );

    // Output mute after init, frequency change and profile switch
    srm_mute_ctrl srm_mute_ctrl_inst (
        .clk_in(mclk_in),
        .rst_n_in(rst_n),
        .automute_in(mute_settle_cfg[MS_AUTOMUTE_BIT]),
        .vco_change_in(vco_change_in),
        .profile_switch_in(profile_switch_in),
        .lock_in(lock_in),
        .muted_out(muted_out)
    );

    // Buffer types and reference input controls come straight from flops, except the differential select, which the crystal buffer bit gates
    assign transmit_buffer_type_out = mute_settle_cfg[MS_TX_TYPE_BIT]; // R11
    assign receive_buffer_type_out = mute_settle_cfg[MS_RX_TYPE_BIT]; // R11
    assign ref_input_termination_out = ref_mod_cfg[RM_TERM_BIT]; // R12
    assign crystal_buffer_enable_out = ref_mod_cfg[RM_CRYSTAL_BUFFER_ENABLE_BIT];
    // Crystal buffer overrides the input kind selection
    assign ref_input_differential_out =
        ref_mod_cfg[RM_KIND_BIT] && !ref_mod_cfg[RM_CRYSTAL_BUFFER_ENABLE_BIT]; // R13 R15
    // Reserved codes pass through unchanged; software must avoid them
    assign crystal_series_resistor_out = ref_mod_cfg[RM_XRES_LSB +: 3]; // R14

    // Mode field has its two select bits stored in swapped order
    assign mode = {ref_mod_cfg[RM_MODE_SEL1_BIT], ref_mod_cfg[RM_MODE_SEL0_BIT]}; // R21
    assign modulation_source_mode_out = mode; // R21
    assign level_mode = (mode == MODE_PIN) || (mode == MODE_REG);
    assign shift_level_count_out = ref_mod_cfg[RM_LEVEL_LSB +: 2]; // R18

    // Level zero disables pin and register modes despite the profile enable
    assign modulation_enable_out = profile_modulation_enable_in &&
        !(level_mode && (ref_mod_cfg[RM_LEVEL_LSB +: 2] == 2'h0)); // R19

    // Deviation word index applies in register mode only
    assign deviation_index_out =
        (mode == MODE_REG) ? ref_mod_cfg[RM_DEV_LSB +: 3] : 3'h0; // R20

    // Serial clock edge tracking for the serial audio mode
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            serial_clk_prev <= 1'b0;
        end else begin
            serial_clk_prev <= serial_clk_in;
        end
    end

    // Pick rising or falling edge by the polarity bit
    assign sample_edge = ref_mod_cfg[RM_CLK_POL_BIT] ?
        (serial_clk_prev && !serial_clk_in) : (!serial_clk_prev && serial_clk_in); // R17

    // Strobe and frame-sync level are registered and only live in serial mode
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            serial_clock_strobe_out <= 1'b0;
            frame_sync_active_out <= 1'b0;
        end else begin
            serial_clock_strobe_out <= (mode == MODE_SERIAL) && sample_edge; // R17
            frame_sync_active_out <= (mode == MODE_SERIAL) &&
                (frame_sync_in ^ ref_mod_cfg[RM_FS_POL_BIT]); // R16
        end
    end

    // Pin follows lock one edge later when lock is selected and lock detect is enabled
    property p_pin_lock;
        @(posedge mclk_in) disable iff (!rst_n)
        lock_det_cfg[LD_PIN_SEL_BIT] && lock_det_cfg[LOCK_DETECT_ENABLE_BIT] && $stable(lock_det_cfg)
            |=> multipurpose_output_pin_out == $past(lock_in);
    endproperty
    a_pin_lock: assert property (p_pin_lock) else $error("pin not lock"); // R3

    // Pin carries readback data when selected
    property p_pin_readback;
        @(posedge mclk_in) disable iff (!rst_n)
        !lock_det_cfg[LD_PIN_SEL_BIT] ##1 !$past(lock_det_cfg[LD_PIN_SEL_BIT])
            |-> multipurpose_output_pin_out == $past(readback_data_in);
    endproperty
    a_pin_readback: assert property (p_pin_readback) else $error("pin not readback"); // R3

    // Disabled lock detect never reports lock
    property p_lock_gated;
        @(posedge mclk_in) disable iff (!rst_n)
        !lock_det_cfg[LOCK_DETECT_ENABLE_BIT] |=> !lock_detect_out;
    endproperty
    a_lock_gated: assert property (p_lock_gated) else $error("lock while disabled"); // R4

    // A switch start while idle makes the settle wait busy on the next edge
    property p_settle_start;
        @(posedge mclk_in) disable iff (!rst_n)
        switch_start_in && !settle_busy_out |=> settle_busy_out;
    endproperty
    a_settle_start: assert property (p_settle_start) else $error("no settle wait"); // R8

    // Crystal buffer always forces the non-differential path
    property p_xtal_override;
        @(posedge mclk_in) disable iff (!rst_n)
        crystal_buffer_enable_out |-> !ref_input_differential_out;
    endproperty
    a_xtal_override: assert property (p_xtal_override) else $error("kind not overridden"); // R15

    // Level zero in pin or register mode keeps modulation off
    property p_level_zero;
        @(posedge mclk_in) disable iff (!rst_n)
        level_mode && shift_level_count_out == 2'h0 |-> !modulation_enable_out;
    endproperty
    a_level_zero: assert property (p_level_zero) else $error("modulation on at level 0"); // R19

    // A write to the mute register reads back in the next cycle
    property p_write_back;
        @(posedge mclk_in) disable iff (!rst_n)
        wr_pending && wr_index == IDX_MUTE_SETTLE |=> mute_settle_cfg == $past(hwdata_in[15:0]);
    endproperty
    a_write_back: assert property (p_write_back) else $error("write lost"); // R22

    // No strobe outside serial mode
    property p_strobe_mode;
        @(posedge mclk_in) disable iff (!rst_n)
        serial_clock_strobe_out |-> $past(mode) == MODE_SERIAL;
    endproperty
    a_strobe_mode: assert property (p_strobe_mode) else $error("strobe outside serial"); // R17
endmodule
`default_nettype wire

// >>> srm_pkg.sv
// Shared constants for the reference, mute and modulation register slice.
// Assumes a 32-bit AHB-Lite bus where each register sits in one aligned word.
package srm_pkg;
    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_REF_MOD = 8'h22;
    localparam logic [7:0] IDX_MUTE_SETTLE = 8'h23;
    localparam logic [7:0] IDX_LOCK_DET = 8'h27;
    // Reset values
    localparam logic [15:0] RST_REF_MOD = 16'h1000;
    localparam logic [15:0] RST_MUTE_SETTLE = 16'h0647;
    localparam logic [15:0] RST_LOCK_DET = 16'h11F0;
    // Lock detect configuration fields
    localparam int LOCK_DETECT_ENABLE_BIT = 0;
    localparam int LD_PIN_SEL_BIT = 3;
    // Mute and settle fields
    localparam int MS_RX_TYPE_BIT = 0;
    localparam int MS_TX_TYPE_BIT = 1;
    localparam int MS_AUTOMUTE_BIT = 2;
    localparam int MS_SETTLE_LSB = 3;
    localparam int MS_SETTLE_W = 11;
    // Reference and modulation fields
    localparam int RM_MODE_SEL0_BIT = 1;
    localparam int RM_MODE_SEL1_BIT = 0;
    localparam int RM_DEV_LSB = 2;
    localparam int RM_LEVEL_LSB = 5;
    localparam int RM_CLK_POL_BIT = 7;
    localparam int RM_FS_POL_BIT = 8;
    localparam int RM_CRYSTAL_BUFFER_ENABLE_BIT = 10;
    localparam int RM_XRES_LSB = 11;
    localparam int RM_KIND_BIT = 14;
    localparam int RM_TERM_BIT = 15;
    // Modulation source modes
    localparam logic [1:0] MODE_PIN = 2'h0;
    localparam logic [1:0] MODE_REG = 2'h1;
    localparam logic [1:0] MODE_SERIAL = 2'h2;
    localparam logic [1:0] MODE_FAST = 2'h3;
    // AHB transfer type that starts a transfer
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    // Settle counter states, one-hot
    typedef enum logic [1:0] {
        SRM_ST_IDLE = 2'h1,
        SRM_ST_WAIT = 2'h2
    } srm_settle_state_t;
endpackage

// >>> srm_settle_timer.sv
// Multiplier settle wait: counts reference clock ticks after a switch start.
// Assumes ref_tick_in is a one-cycle pulse per reference cycle.
`timescale 1ns/1ps
`default_nettype none
module srm_settle_timer
    import srm_pkg::*;
#(
    parameter int CW = 11
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Control
    input wire logic start_in,
    input wire logic ref_tick_in,
    input wire logic [CW-1:0] count_in,
    // Status
    output logic busy_out,
    output logic done_out
);
    srm_settle_state_t state; // Current state
    logic [CW-1:0] ticks; // Reference cycles seen so far

    // Wait for the programmed count; a zero count is illegal and ends at once
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= SRM_ST_IDLE;
            ticks <= '0;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            unique case (state)
                SRM_ST_IDLE: begin
                    if (start_in) begin // R6 R8
                        ticks <= '0;
                        state <= SRM_ST_WAIT;
                    end
                end
                SRM_ST_WAIT: begin
                    if (ticks >= count_in) begin // R6
                        done_out <= 1'b1;
                        state <= SRM_ST_IDLE;
                    end else if (ref_tick_in) begin
                        ticks <= ticks + 1'b1;
                    end
                end
                default: state <= SRM_ST_IDLE;
            endcase
        end
    end

    assign busy_out = (state == SRM_ST_WAIT);

    // Done only ever ends a wait
    property p_done_after_wait;
        @(posedge clk_in) disable iff (!rst_n_in)
        done_out |-> $past(busy_out) && !busy_out;
    endproperty
    a_done_after_wait: assert property (p_done_after_wait) else $error("done without wait"); // R6
endmodule
`default_nettype wire

// >>> srm_mute_ctrl.sv
// Output auto-mute: mutes after qualifying events until the loop locks.
// Assumes lock_in is the loop lock indication, synchronous to clk_in.
`timescale 1ns/1ps
`default_nettype none
module srm_mute_ctrl (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Control and events
    input wire logic automute_in,
    input wire logic vco_change_in,
    input wire logic profile_switch_in,
    input wire logic lock_in,
    // Result
    output logic muted_out
);
    logic init_pending; // Initialization counts as a qualifying event
    logic event_now; // Any qualifying event this cycle

    assign event_now = init_pending | vco_change_in | profile_switch_in;

    // Init event fires once, on the first edge after reset release
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            init_pending <= 1'b1;
        end else begin
            init_pending <= 1'b0;
        end
    end

    // An event wins over a lock in the same cycle; lock loss never re-mutes
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            muted_out <= 1'b0;
        end else if (event_now && automute_in) begin
            muted_out <= 1'b1; // R9
        end else if (lock_in || !automute_in) begin
            muted_out <= 1'b0; // R9
        end
    end

    // Once unmuted, only an event can mute again
    property p_no_remute;
        @(posedge clk_in) disable iff (!rst_n_in)
        !muted_out ##1 muted_out |-> $past(event_now) && $past(automute_in);
    endproperty
    a_no_remute: assert property (p_no_remute) else $error("muted without event"); // R10

    // Muted state clears one edge after lock
    property p_unmute_on_lock;
        @(posedge clk_in) disable iff (!rst_n_in)
        muted_out && lock_in && !event_now |=> !muted_out;
    endproperty
    a_unmute_on_lock: assert property (p_unmute_on_lock) else $error("stayed muted"); // R9
endmodule
`default_nettype wire

// >>> srm_top_tb.sv
// Self-checking bench for the reference, mute and modulation register slice.
// Assumes the slice answers every AHB-Lite transfer with zero wait states.
`timescale 1ns/1ps
`default_nettype none
module srm_top_tb
    import srm_pkg::*;
;
    // Clock, reset and bus master signals
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic hsel = 1'b0;
    logic [9:0] haddr = 10'h000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    // Loop, sequencing and modulation stimulus
    logic rb = 1'b0, lock = 1'b0, rtick = 1'b0, sstart = 1'b0;
    logic vco = 1'b0, pswitch = 1'b0, pmen = 1'b1, fs = 1'b0, sclk = 1'b0;
    // Design outputs
    logic [31:0] hrdata;
    logic hready, hresp, pin, ld, busy, done, muted, txt, rxt, term, diff, xen, men, fsa, stb;
    logic [2:0] xres, dev;
    logic [1:0] mode, lvl;
    int err_total = 0;
    int comparisons = 0;

    // Half period of 4 ns gives 125 MHz
    always #4 mclk = ~mclk;

    srm_top srm_top_inst (.mclk_in(mclk), .resetn_in(resetn), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
        .hready_in(hready), .hwdata_in(hwdata), .hrdata_out(hrdata),
        .hreadyout_out(hready), .hresp_out(hresp), .readback_data_in(rb), .lock_in(lock),
        .ref_tick_in(rtick), .switch_start_in(sstart), .vco_change_in(vco),
        .profile_switch_in(pswitch), .profile_modulation_enable_in(pmen),
        .frame_sync_in(fs), .serial_clk_in(sclk), .multipurpose_output_pin_out(pin),
        .lock_detect_out(ld), .settle_busy_out(busy), .settle_done_out(done),
        .muted_out(muted), .transmit_buffer_type_out(txt), .receive_buffer_type_out(rxt),
        .ref_input_termination_out(term), .ref_input_differential_out(diff),
        .crystal_buffer_enable_out(xen), .crystal_series_resistor_out(xres),
        .modulation_source_mode_out(mode), .modulation_enable_out(men),
        .shift_level_count_out(lvl), .deviation_index_out(dev),
        .frame_sync_active_out(fsa), .serial_clock_strobe_out(stb));

    // Verdict and end of run, reached from the main sequence or a timeout
    task automatic summarize;
        if (err_total == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Timeout: counts as a mismatch and ends the run
    task automatic give_up;
        err_total++;
        summarize();
    endtask

    // One compare for every value; narrow outputs are zero-extended, X stays visible
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Waits for hready at a rising edge, never longer than the bound
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        if (hready !== 1'b1) begin
            give_up();
        end
    endtask

    // Single word transfer; address phase then data phase, both held until hready
    task automatic ahb(input logic wr, input logic [9:0] a, input logic [15:0] d,
                       output logic [31:0] q);
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        hwrite <= 1'b0;
        hwdata <= {16'h0, d};
        wait_ready();
        // Read data is taken at the edge that ends the data phase
        q = hrdata;
        chk("hresp", 32'h0, hresp);
    endtask

    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [9:0] a, input logic [31:0] e);
        logic [31:0] q;
        ahb(1'b0, a, 16'h0, q);
        chk("hrdata", e, q);
    endtask

    // Reset values, unmapped read, reset-time decode of the output controls
    task automatic t_reset;
        rd_chk(10'h088, {16'h0, RST_REF_MOD});
        rd_chk(10'h08C, {16'h0, RST_MUTE_SETTLE});
        rd_chk(10'h09C, {16'h0, RST_LOCK_DET});
        rd_chk(10'h000, 32'h0);
        chk("xres", 3'h2, xres);
        chk("txt", 1'b1, txt);
        chk("rxt", 1'b1, rxt);
    endtask

    // One qualifying event mutes until lock, losing lock later does not re-mute
    task automatic t_event(input logic use_vco);
        @(posedge mclk);
        vco <= use_vco;
        pswitch <= ~use_vco;
        @(posedge mclk);
        vco <= 1'b0;
        pswitch <= 1'b0;
        #1;
        chk("muted", 1'b1, muted);
        @(posedge mclk);
        lock <= 1'b1;
        tick(2);
        #1;
        chk("muted", 1'b0, muted);
        @(posedge mclk);
        lock <= 1'b0;
        tick(3);
        #1;
        chk("muted", 1'b0, muted);
    endtask

    // Init mute is set by the reset value of the auto-mute bit
    task automatic t_mute;
        chk("muted", 1'b1, muted);
        @(posedge mclk);
        lock <= 1'b1;
        tick(2);
        #1;
        chk("muted", 1'b0, muted);
        @(posedge mclk);
        lock <= 1'b0;
        tick(3);
        #1;
        chk("muted", 1'b0, muted);
        t_event(1'b1);
        t_event(1'b0);
    endtask

    // Settle count of 3 ticks; must still be busy after only two
    task automatic t_settle;
        int n;
        wr(10'h08C, 16'h001D);
        tick(1);
        #1;
        chk("txt", 1'b0, txt);
        chk("rxt", 1'b1, rxt);
        rd_chk(10'h08C, 32'h001D);
        @(posedge mclk);
        sstart <= 1'b1;
        @(posedge mclk);
        sstart <= 1'b0;
        #1;
        chk("busy", 1'b1, busy);
        for (n = 0; n < 3; n++) begin
            if (n == 2) begin
                chk("done", 1'b0, done);
                chk("busy", 1'b1, busy);
            end
            @(posedge mclk);
            rtick <= 1'b1;
            @(posedge mclk);
            rtick <= 1'b0;
            #1;
        end
        n = 0;
        while (done !== 1'b1) begin
            if (n == 8) begin
                give_up();
            end
            @(posedge mclk);
            #1;
            n++;
        end
        @(posedge mclk);
        #1;
        chk("busy", 1'b0, busy);
        chk("done", 1'b0, done);
    endtask

    // Pin select and lock detect enable, with the mandated reserved values
    task automatic t_lock;
        wr(10'h09C, 16'h11FB);
        @(posedge mclk);
        lock <= 1'b1;
        tick(2);
        #1;
        chk("ld", 1'b1, ld);
        chk("pin", 1'b1, pin);
        wr(10'h09C, 16'h11F2);
        @(posedge mclk);
        rb <= 1'b1;
        tick(2);
        #1;
        chk("ld", 1'b0, ld);
        chk("pin", 1'b1, pin);
        @(posedge mclk);
        rb <= 1'b0;
        tick(2);
        #1;
        chk("pin", 1'b0, pin);
    endtask

    // Reference input options, levels, deviation select and every mode code
    task automatic t_refmod;
        logic [1:0] m;
        wr(10'h088, 16'hD856);
        tick(1);
        #1;
        chk("term", 1'b1, term);
        chk("diff", 1'b1, diff);
        chk("xres", 3'h3, xres);
        chk("mode", MODE_REG, mode);
        chk("lvl", 2'h2, lvl);
        chk("dev", 3'h5, dev);
        chk("men", 1'b1, men);
        rd_chk(10'h088, 32'hD856);
        wr(10'h088, 16'hDC16);
        tick(1);
        #1;
        chk("xen", 1'b1, xen);
        chk("diff", 1'b0, diff);
        chk("men", 1'b0, men);
        for (int i = 0; i < 4; i++) begin
            m = i[1:0];
            wr(10'h088, {14'h0, m[0], m[1]});
            tick(1);
            #1;
            chk("mode", m, mode);
        end
    endtask

    // Serial mode: inverted frame sync, falling clock edge strobe only
    task automatic t_serial;
        int n;
        wr(10'h088, 16'h8181);
        @(posedge mclk);
        sclk <= 1'b1;
        tick(3);
        #1;
        chk("term", 1'b1, term);
        chk("diff", 1'b0, diff);
        chk("dev", 3'h0, dev);
        chk("fsa", 1'b1, fsa);
        chk("stb", 1'b0, stb);
        @(posedge mclk);
        fs <= 1'b1;
        sclk <= 1'b0;
        n = 0;
        while (stb !== 1'b1) begin
            if (n == 6) begin
                give_up();
            end
            @(posedge mclk);
            #1;
            n++;
        end
        tick(1);
        #1;
        chk("fsa", 1'b0, fsa);
        chk("stb", 1'b0, stb);
    endtask

    // Main sequence: reset held for 4 cycles, first check at the 3rd edge after release
    initial begin
        tick(4);
        resetn <= 1'b1;
        tick(3);
        #1;
        t_mute();
        t_reset();
        t_settle();
        t_lock();
        t_refmod();
        t_serial();
        summarize();
    end

    // Whole-run limit against a hang anywhere in the sequence
    initial begin
        tick(20000);
        give_up();
    end
endmodule
`default_nettype wire
